// ---- include/kbd_ptr_pkg.sv ----
/*
  Shared constants and carrier types for the keyboard and pointer event
  encoder: link codes, timing figures, setting ranges and packet layout.
  Assumes a single 200 MHz clock domain for every user of the package.
*/
package kbd_ptr_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_MS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int TICK_NS = TICK_MS * NS_PER_MS;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int RESET_MS = 100;
  localparam int RESET_TICKS = RESET_MS / TICK_MS;

  // link bytes
  localparam logic [7:0] PTR_HEADER = 8'hfd;
  localparam logic [7:0] HOST_ACK = 8'hfe;
  localparam int RELEASE_BIT = 7;

  // settings: 99 steps, values 0 to 98
  localparam int SETTING_W = 7;
  localparam int SETTING_STEPS = 99;
  localparam logic [SETTING_W-1:0] SETTING_MAX = 7'h62;
  localparam logic [SETTING_W-1:0] SETTING_MIN = 7'h00;
  localparam logic [SETTING_W-1:0] SETTING_RESET = 7'h31;

  // pointer packet
  localparam int SENSOR_W = 10;
  localparam int MAG_W = 3;
  localparam logic [MAG_W-1:0] MAG_MAX = 3'h7;

  localparam int PARAM_W = 8;

  typedef struct packed {
    logic release_flag;   // 1 = key released
    logic [6:0] code;     // scan code
  } key_event_t;

  typedef struct packed {
    logic [SENSOR_W-1:0] left;
    logic [SENSOR_W-1:0] right;
    logic [SENSOR_W-1:0] up;
    logic [SENSOR_W-1:0] down;
  } sensor_set_t;

  typedef struct packed {
    logic y_ovf;
    logic x_ovf;
    logic y_neg;
    logic x_neg;
    logic event_flag;
    logic mid_btn;
    logic right_btn;
    logic left_btn;
  } pointer_status_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_ACK,
    TX_KEY,
    TX_HDR,
    TX_STAT,
    TX_XMAG,
    TX_YMAG
  } tx_state_t;

endpackage

// ---- hw/kbd_ptr_encoder.sv ----
/*
  Keyboard and pressure-pad pointer event encoder: key press/release
  codes, auto-repeat, hot-key trapping for brightness, contrast and
  reset, and four-byte pointer packets, all sent as raw bytes to the host.
  Assumes the key scanner, sensor converter and host link logic all run
  on clk; repeat and scan parameters come from nonvolatile storage.
*/
// How it works
// - key press sends its code; release sends the code with bit 7 set.
// - repeat delay and repeat interval are inputs counted in 10 ms ticks.
// - after the delay, the last pressed held key resends every interval.
// - ALT+UP/DOWN, ALT+LEFT/RIGHT and ALT+ESC+R are trapped, not forwarded.
// - during a trapped combination only ALT press and release reach host.
// - a held hot-key combination repeats its action at the repeat rate.
// - brightness has 99 steps; UP lowers the value, DOWN raises, saturating.
// - contrast works the same, stepped by ALT+LEFT and ALT+RIGHT.
// - reset combination sets user-reset flag, holds reset low 100 ms.
// - X motion is right minus left pressure; Y is up minus down.
// - first sensor sample after reset is the calibration baseline.
// - a pointer event is header FD, status, X magnitude, Y magnitude.
// - status bits: overflows, signs, event flag, middle, right, left.
// - magnitudes are 0 to 7; overflow bits always sent as zero.
// - event flag cleared at reset; button key changes set it.
// - each scan handles keyboard input first, then pointer scan.
// - net motion fills signs and magnitudes and sets the event flag.
// - at scan end a set event flag sends one packet, then clears.
// - pressure quantizes to eight levels, 64 units per step.
// - pointer scan period is an input in 10 ms ticks, kept externally.
// - all link bytes are raw values, never text characters.
// - keys not used as commands are forwarded to the host.
// - each host request is answered by FE before normal traffic resumes.
module kbd_ptr_encoder
  import kbd_ptr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int MAG_SHIFT = 6,
  parameter logic [6:0] KEY_ALT = 7'h38,
  parameter logic [6:0] KEY_UP = 7'h48,
  parameter logic [6:0] KEY_DOWN = 7'h50,
  parameter logic [6:0] KEY_LEFT = 7'h4b,
  parameter logic [6:0] KEY_RIGHT = 7'h4d,
  parameter logic [6:0] KEY_ESC = 7'h01,
  parameter logic [6:0] KEY_R = 7'h13,
  parameter logic [6:0] KEY_BTN_L = 7'h5b,
  parameter logic [6:0] KEY_BTN_M = 7'h5c,
  parameter logic [6:0] KEY_BTN_R = 7'h5d
) (
  input wire logic clk,                          // 200 MHz clock
  input wire logic srst,                         // sync reset, high
  input wire logic ce,                           // clock enable
  input wire logic key_valid,                    // scanner event valid
  input wire kbd_ptr_pkg::key_event_t key_in,    // scanner event
  output logic key_ready,                        // event accepted
  input wire logic sensor_valid,                 // new sensor sample
  input wire kbd_ptr_pkg::sensor_set_t sensor_in, // four readings
  input wire logic host_req,                     // host request pulse
  input wire logic [7:0] repeat_delay,           // ticks before repeat
  input wire logic [7:0] repeat_interval,        // ticks between repeats
  input wire logic [7:0] scan_period,            // ticks between scans
  output logic tx_valid,                         // byte to host valid
  output logic [7:0] tx_data,                    // byte to host
  input wire logic tx_ready,                     // link takes byte
  output logic [6:0] brightness,                 // brightness pot value
  output logic [6:0] contrast,                   // contrast pot value
  output logic user_reset,                       // user-reset status
  output logic sys_rst_n                         // system reset, low
);

  // ---------------- time base ----------------
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;

  always_comb begin
    tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt_r <= '0;
    end else if (ce) begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // ---------------- keyboard group ----------------
  logic alt_r, up_r, down_r, left_r, right_r, esc_r, rkey_r;
  logic alt_nxt, up_nxt, down_nxt, left_nxt, right_nxt, esc_nxt, rkey_nxt;
  logic kpend_r, kpend_nxt;
  logic [7:0] kbyte_r, kbyte_nxt;
  logic [6:0] last_r, last_nxt;
  logic last_hot_r, last_hot_nxt;
  logic rpt_on_r, rpt_on_nxt, rpt_go_r, rpt_go_nxt;
  logic [7:0] rpt_cnt_r, rpt_cnt_nxt;
  logic [6:0] bright_r, bright_nxt, contr_r, contr_nxt;
  logic ures_r, ures_nxt, rst_on_r, rst_on_nxt;
  logic [7:0] rst_cnt_r, rst_cnt_nxt;
  logic [2:0] btn_r, btn_nxt;
  logic btn_evt;
  logic key_sent;
  logic key_acc, rel, is_hot, is_btn, act_en;
  logic [6:0] code, act_code;

  assign key_ready = ce & ~kpend_r;
  assign brightness = bright_r;
  assign contrast = contr_r;
  assign user_reset = ures_r;
  assign sys_rst_n = ~rst_on_r;

  always_comb begin
    alt_nxt = alt_r;
    up_nxt = up_r;
    down_nxt = down_r;
    left_nxt = left_r;
    right_nxt = right_r;
    esc_nxt = esc_r;
    rkey_nxt = rkey_r;
    kpend_nxt = kpend_r & ~key_sent;
    kbyte_nxt = kbyte_r;
    last_nxt = last_r;
    last_hot_nxt = last_hot_r;
    rpt_on_nxt = rpt_on_r;
    rpt_go_nxt = rpt_go_r;
    rpt_cnt_nxt = rpt_cnt_r;
    bright_nxt = bright_r;
    contr_nxt = contr_r;
    ures_nxt = ures_r;
    rst_on_nxt = rst_on_r;
    rst_cnt_nxt = rst_cnt_r;
    btn_nxt = btn_r;
    btn_evt = 1'b0;
    act_en = 1'b0;
    act_code = '0;
    key_acc = key_valid & key_ready;
    rel = key_in.release_flag;
    code = key_in.code;
    is_hot = (code == KEY_UP) || (code == KEY_DOWN) || (code == KEY_LEFT) ||
             (code == KEY_RIGHT) || (code == KEY_ESC) || (code == KEY_R);
    is_btn = (code == KEY_BTN_L) || (code == KEY_BTN_M) ||
             (code == KEY_BTN_R);
    if (key_acc) begin
      if (code == KEY_UP) up_nxt = ~rel;
      if (code == KEY_DOWN) down_nxt = ~rel;
      if (code == KEY_LEFT) left_nxt = ~rel;
      if (code == KEY_RIGHT) right_nxt = ~rel;
      if (code == KEY_ESC) esc_nxt = ~rel;
      if (code == KEY_R) rkey_nxt = ~rel;
      if (rel && code == last_r) rpt_on_nxt = 1'b0;
      if (code == KEY_ALT) begin
        alt_nxt = ~rel;
        kpend_nxt = 1'b1;
        kbyte_nxt = {rel, code};
        if (rel && last_hot_r) rpt_on_nxt = 1'b0;
      end else if (is_btn) begin
        // simulated mouse buttons
        if (code == KEY_BTN_L) btn_nxt[0] = ~rel;
        if (code == KEY_BTN_R) btn_nxt[1] = ~rel;
        if (code == KEY_BTN_M) btn_nxt[2] = ~rel;
        btn_evt = 1'b1;
      end else if (alt_r && is_hot) begin
        if (!rel) begin
          act_en = 1'b1;
          act_code = code;
          last_nxt = code;
          last_hot_nxt = 1'b1;
          rpt_on_nxt = 1'b1;
          rpt_go_nxt = 1'b0;
          rpt_cnt_nxt = '0;
        end
      end else begin
        kpend_nxt = 1'b1;
        kbyte_nxt[RELEASE_BIT] = rel;
        kbyte_nxt[6:0] = code;
        if (!rel) begin
          last_nxt = code;
          last_hot_nxt = 1'b0;
          rpt_on_nxt = 1'b1;
          rpt_go_nxt = 1'b0;
          rpt_cnt_nxt = '0;
        end
      end
    end else if (tick && rpt_on_r) begin
      if (rpt_cnt_r + 8'h1 >= (rpt_go_r ? repeat_interval
                                        : repeat_delay)) begin
        rpt_cnt_nxt = '0;
        rpt_go_nxt = 1'b1;
        if (last_hot_r) begin
          act_en = alt_r;
          act_code = last_r;
        end else if (!kpend_r) begin
          kpend_nxt = 1'b1;
          kbyte_nxt = {1'b0, last_r};
        end
      end else begin
        rpt_cnt_nxt = rpt_cnt_r + 8'h1;
      end
    end
    if (act_en) begin
      if (act_code == KEY_UP && bright_r != SETTING_MIN)
        bright_nxt = bright_r - 7'h1;
      if (act_code == KEY_DOWN && bright_r != SETTING_MAX)
        bright_nxt = bright_r + 7'h1;
      if (act_code == KEY_LEFT && contr_r != SETTING_MIN)
        contr_nxt = contr_r - 7'h1;
      if (act_code == KEY_RIGHT && contr_r != SETTING_MAX)
        contr_nxt = contr_r + 7'h1;
      if ((act_code == KEY_ESC || act_code == KEY_R) &&
          esc_nxt && rkey_nxt && !rst_on_r) begin
        ures_nxt = 1'b1;
        rst_on_nxt = 1'b1;
        rst_cnt_nxt = '0;
      end
    end
    if (rst_on_r && tick) begin
      if (rst_cnt_r == 8'(RESET_TICKS - 1)) begin
        rst_on_nxt = 1'b0;
      end else begin
        rst_cnt_nxt = rst_cnt_r + 8'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alt_r <= 1'b0;
      up_r <= 1'b0;
      down_r <= 1'b0;
      left_r <= 1'b0;
      right_r <= 1'b0;
      esc_r <= 1'b0;
      rkey_r <= 1'b0;
      kpend_r <= 1'b0;
      kbyte_r <= '0;
      last_r <= '0;
      last_hot_r <= 1'b0;
      rpt_on_r <= 1'b0;
      rpt_go_r <= 1'b0;
      rpt_cnt_r <= '0;
      bright_r <= SETTING_RESET;
      contr_r <= SETTING_RESET;
      ures_r <= 1'b0;
      rst_on_r <= 1'b0;
      rst_cnt_r <= '0;
      btn_r <= '0;
    end else if (ce) begin
      alt_r <= alt_nxt;
      up_r <= up_nxt;
      down_r <= down_nxt;
      left_r <= left_nxt;
      right_r <= right_nxt;
      esc_r <= esc_nxt;
      rkey_r <= rkey_nxt;
      kpend_r <= kpend_nxt;
      kbyte_r <= kbyte_nxt;
      last_r <= last_nxt;
      last_hot_r <= last_hot_nxt;
      rpt_on_r <= rpt_on_nxt;
      rpt_go_r <= rpt_go_nxt;
      rpt_cnt_r <= rpt_cnt_nxt;
      bright_r <= bright_nxt;
      contr_r <= contr_nxt;
      ures_r <= ures_nxt;
      rst_on_r <= rst_on_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      btn_r <= btn_nxt;
    end
  end

  // ---------------- pointer and transmit group ----------------
  function automatic logic [MAG_W-1:0] quant(input logic [SENSOR_W:0] d);
    logic [SENSOR_W:0] a;
    logic [SENSOR_W:0] s;
    a = d[SENSOR_W] ? -d : d;
    s = a >> MAG_SHIFT;
    quant = (s > SENSOR_W'(MAG_MAX)) ? MAG_MAX : s[MAG_W-1:0];
  endfunction

  function automatic logic [SENSOR_W-1:0] press(
    input logic [SENSOR_W-1:0] v,
    input logic [SENSOR_W-1:0] b
  );
    press = (v > b) ? v - b : '0;
  endfunction

  sensor_set_t base_r, base_nxt, samp_r, samp_nxt;
  logic cal_r, cal_nxt, have_r, have_nxt;
  logic [7:0] scan_cnt_r, scan_cnt_nxt;
  logic scan_due_r, scan_due_nxt;
  pointer_status_t stat_r, stat_nxt, pkt_stat_r, pkt_stat_nxt;
  logic [MAG_W-1:0] mx_r, mx_nxt, my_r, my_nxt;
  logic pkt_req_r, pkt_req_nxt, ack_r, ack_nxt;
  tx_state_t st_r, st_nxt;
  logic [7:0] txd_r, txd_nxt;
  logic [SENSOR_W:0] dx, dy;
  logic take;

  assign tx_valid = ce & (st_r != TX_IDLE);
  assign tx_data = txd_r;

  always_comb begin
    base_nxt = base_r;
    samp_nxt = samp_r;
    cal_nxt = cal_r;
    have_nxt = have_r;
    scan_cnt_nxt = scan_cnt_r;
    scan_due_nxt = 1'b0;
    stat_nxt = stat_r;
    pkt_stat_nxt = pkt_stat_r;
    mx_nxt = mx_r;
    my_nxt = my_r;
    pkt_req_nxt = pkt_req_r;
    ack_nxt = ack_r;
    st_nxt = st_r;
    txd_nxt = txd_r;
    key_sent = 1'b0;
    take = tx_valid & tx_ready;
    dx = {1'b0, press(samp_r.right, base_r.right)} -
         {1'b0, press(samp_r.left, base_r.left)};
    dy = {1'b0, press(samp_r.up, base_r.up)} -
         {1'b0, press(samp_r.down, base_r.down)};
    if (sensor_valid) begin
      samp_nxt = sensor_in;
      have_nxt = 1'b1;
      if (!cal_r) begin
        base_nxt = sensor_in;
        cal_nxt = 1'b1;
      end
    end
    if (tick) begin
      if (scan_cnt_r + 8'h1 >= scan_period) begin
        scan_cnt_nxt = '0;
        scan_due_nxt = 1'b1;
      end else begin
        scan_cnt_nxt = scan_cnt_r + 8'h1;
      end
    end
    // button bits come from the keyboard pass, one cycle ahead of the scan
    stat_nxt.left_btn = btn_r[0];
    stat_nxt.right_btn = btn_r[1];
    stat_nxt.mid_btn = btn_r[2];
    stat_nxt.y_ovf = 1'b0;
    stat_nxt.x_ovf = 1'b0;
    if (scan_due_r && have_r && !pkt_req_r) begin
      if (dx != '0 || dy != '0) begin
        stat_nxt.x_neg = dx[SENSOR_W];
        stat_nxt.y_neg = dy[SENSOR_W];
        mx_nxt = (dx != '0) ? quant(dx) : '0;
        my_nxt = (dy != '0) ? quant(dy) : '0;
        stat_nxt.event_flag = 1'b1;
      end else begin
        mx_nxt = '0;
        my_nxt = '0;
      end
      if (stat_nxt.event_flag && !pkt_req_r) begin
        pkt_req_nxt = 1'b1;
        pkt_stat_nxt = stat_nxt;
        stat_nxt.event_flag = 1'b0;
      end
    end
    if (btn_evt) stat_nxt.event_flag = 1'b1;
    if (host_req) ack_nxt = 1'b1;
    case (st_r)
      TX_IDLE: begin
        if (ack_r) begin
          st_nxt = TX_ACK;
          txd_nxt = HOST_ACK;
        end else if (pkt_req_r) begin
          st_nxt = TX_HDR;
          txd_nxt = PTR_HEADER;
        end else if (kpend_r) begin
          st_nxt = TX_KEY;
          txd_nxt = kbyte_r;
        end
      end
      TX_ACK: begin
        if (take) begin
          st_nxt = TX_IDLE;
          ack_nxt = host_req;
        end
      end
      TX_KEY: begin
        if (take) begin
          st_nxt = TX_IDLE;
          key_sent = 1'b1;
        end
      end
      TX_HDR: begin
        if (take) begin
          st_nxt = TX_STAT;
          txd_nxt = pkt_stat_r;
        end
      end
      TX_STAT: begin
        if (take) begin
          st_nxt = TX_XMAG;
          txd_nxt = {5'h00, mx_r};
        end
      end
      TX_XMAG: begin
        if (take) begin
          st_nxt = TX_YMAG;
          txd_nxt = {5'h00, my_r};
        end
      end
      TX_YMAG: begin
        if (take) begin
          st_nxt = TX_IDLE;
          pkt_req_nxt = 1'b0;
        end
      end
      default: st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      base_r <= '0;
      samp_r <= '0;
      cal_r <= 1'b0;
      have_r <= 1'b0;
      scan_cnt_r <= '0;
      scan_due_r <= 1'b0;
      stat_r <= '0;
      pkt_stat_r <= '0;
      mx_r <= '0;
      my_r <= '0;
      pkt_req_r <= 1'b0;
      ack_r <= 1'b0;
      st_r <= TX_IDLE;
      txd_r <= '0;
    end else if (ce) begin
      base_r <= base_nxt;
      samp_r <= samp_nxt;
      cal_r <= cal_nxt;
      have_r <= have_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      scan_due_r <= scan_due_nxt;
      stat_r <= stat_nxt;
      pkt_stat_r <= pkt_stat_nxt;
      mx_r <= mx_nxt;
      my_r <= my_nxt;
      pkt_req_r <= pkt_req_nxt;
      ack_r <= ack_nxt;
      st_r <= st_nxt;
      txd_r <= txd_nxt;
    end
  end

endmodule

// ---- verification/kbd_ptr_monitor.sv ----
/*
  Port checker for the key and pointer encoder, bound to its top module.
  Assumes one clock, srst synchronous and held for at least two cycles.
*/
module kbd_ptr_monitor
  import kbd_ptr_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic ce, // clock enable
  input wire logic key_valid, // key event valid
  input wire kbd_ptr_pkg::key_event_t key_in, // key event
  input wire logic key_ready, // key accepted
  input wire logic sensor_valid, // sample valid
  input wire kbd_ptr_pkg::sensor_set_t sensor_in, // readings
  input wire logic host_req, // host request
  input wire logic [7:0] repeat_delay, // repeat delay
  input wire logic [7:0] repeat_interval, // repeat interval
  input wire logic [7:0] scan_period, // scan period
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_data, // byte
  input wire logic tx_ready, // byte taken
  input wire logic [6:0] brightness, // brightness value
  input wire logic [6:0] contrast, // contrast value
  input wire logic user_reset, // user-reset flag
  input wire logic sys_rst_n // system reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lo_cnt_r;
  logic [31:0] lo_cnt_nxt;
  logic take;
  assign take = tx_valid && tx_ready;
  // length of the current low phase of the system reset
  always_comb begin
    lo_cnt_nxt = sys_rst_n ? '0 : lo_cnt_r + 32'h1;
  end
  always_ff @(posedge clk) begin
    lo_cnt_r <= srst ? '0 : lo_cnt_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_tx_hold: assert property (tx_valid && !tx_ready ##1 ce |->
    tx_valid && $stable(tx_data)) else $error("stalled byte changed");
  a_hdr_status: assert property (take && tx_data == PTR_HEADER ##1 ce |->
    tx_valid && tx_data[7:6] == 2'b00 && tx_data[3])
    else $error("bad status after header");
  a_pkt_mag: assert property (
    take && tx_data == PTR_HEADER ##1 take ##1 ce |->
    tx_valid && tx_data[7:3] == 5'h00) else $error("bad x magnitude");
  // 20-2f: never trapped by default
  a_key_take: assert property (key_valid && key_ready &&
    key_in.code[6:4] == 3'h2 |=> !key_ready)
    else $error("key taken but ready stayed");
  a_set_range: assert property (
    brightness <= SETTING_MAX && contrast <= SETTING_MAX)
    else $error("setting out of range");
  a_bright_step: assert property (!$stable(brightness) |->
    brightness == $past(brightness) + 7'h01 ||
    brightness == $past(brightness) - 7'h01) else $error("brightness jump");
  a_rst_flag: assert property ($fell(sys_rst_n) |-> user_reset)
    else $error("reset without user flag");
  a_rst_len: assert property ($rose(sys_rst_n) |->
    lo_cnt_r >= 9 * TICK_CYCLES && lo_cnt_r <= 10 * TICK_CYCLES + 1)
    else $error("system reset length wrong");
  a_ack_due: assert property (host_req && ce |->
    ##[1:12] (tx_valid && tx_data == HOST_ACK)) else $error("ack missing");
  c_pkt: cover property (take && tx_data == PTR_HEADER);
  c_ack: cover property (take && tx_data == HOST_ACK);
  c_rst: cover property ($fell(sys_rst_n));
  c_floor: cover property (brightness == SETTING_MIN);
endmodule

bind kbd_ptr_encoder kbd_ptr_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clk(clk), .srst(srst), .ce(ce), .key_valid(key_valid),
  .key_in(key_in), .key_ready(key_ready), .sensor_valid(sensor_valid),
  .sensor_in(sensor_in), .host_req(host_req), .repeat_delay(repeat_delay),
  .repeat_interval(repeat_interval), .scan_period(scan_period),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .brightness(brightness), .contrast(contrast), .user_reset(user_reset),
  .sys_rst_n(sys_rst_n)
);

// ---- verification/host_link_model.sv ----
/*
  Host end of the byte link: takes raw bytes, stalls at random when asked.
  Assumes a valid/ready handshake on clk; each taken byte is reported.
*/
module host_link_model (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic stall_en, // allow stalls
  input wire logic tx_valid, // byte offered
  input wire logic [7:0] tx_data, // offered byte
  output logic tx_ready, // byte accepted
  output logic rx_stb, // a byte was taken
  output logic [7:0] rx_byte // taken byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr_r <= 8'h5a;
      tx_ready <= 1'b0;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      tx_ready <= !stall_en || lfsr_r[0];
      rx_stb <= tx_valid && tx_ready;
      rx_byte <= tx_data;
    end
  end
endmodule

// ---- verification/tb.sv ----
/*
  Self-checking bench for the key and pointer encoder with a host link
  model on its byte output. Assumes the design's default key codes.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kbd_ptr_pkg::*;
  localparam int TC = 8;
  localparam logic [6:0] K_ALT = 7'h38;
  localparam logic [6:0] K_UP = 7'h48;
  localparam logic [6:0] K_DOWN = 7'h50;
  localparam logic [6:0] K_LEFT = 7'h4b;
  localparam logic [6:0] K_RIGHT = 7'h4d;
  localparam logic [6:0] K_ESC = 7'h01;
  localparam logic [6:0] K_R = 7'h13;
  localparam logic [6:0] K_BTN_L = 7'h5b;
  localparam logic [9:0] BASE = 10'h100;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic key_valid = 1'b0;
  key_event_t key_in = '0;
  logic sensor_valid = 1'b0;
  sensor_set_t sensor_in = '0;
  logic host_req = 1'b0;
  logic stall_en = 1'b0;
  logic [7:0] repeat_delay = 8'h03;
  logic [7:0] repeat_interval = 8'h02;
  logic [7:0] scan_period = 8'h02;
  logic key_ready, tx_valid, tx_ready, rx_stb, user_reset, sys_rst_n;
  logic [7:0] tx_data, rx_byte;
  logic [6:0] brightness, contrast;
  int errors = 0;
  int tests_run = 0;
  int seed = 25;
  logic [7:0] rxq[$];

  always #2.5 clk = ~clk;

  kbd_ptr_encoder #(.TICK_CYCLES(TC)) DUT (
    .clk(clk), .srst(srst), .ce(ce), .key_valid(key_valid),
    .key_in(key_in), .key_ready(key_ready), .sensor_valid(sensor_valid),
    .sensor_in(sensor_in), .host_req(host_req), .repeat_delay(repeat_delay),
    .repeat_interval(repeat_interval), .scan_period(scan_period),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .brightness(brightness), .contrast(contrast), .user_reset(user_reset),
    .sys_rst_n(sys_rst_n));
  host_link_model host (
    .clk(clk), .srst(srst), .stall_en(stall_en), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_stb(rx_stb),
    .rx_byte(rx_byte));

  always @(posedge clk) begin
    if (rx_stb) rxq.push_back(rx_byte);
  end

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail_out();
    errors++;
    give_verdict();
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic send_key(input logic rel, input logic [6:0] c);
    int i;
    @(posedge clk);
    key_valid <= 1'b1;
    key_in <= '{release_flag: rel, code: c};
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (key_ready === 1'b1) break;
    end
    if (i == 300) fail_out();
    key_valid <= 1'b0;
  endtask
  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 400 && rxq.size() == 0; i++) @(posedge clk);
    if (rxq.size() == 0) fail_out();
    b = rxq.pop_front();
  endtask
  task automatic exp_byte(input logic [7:0] e);
    logic [7:0] b;
    get_byte(b);
    chk_byte(b, e);
  endtask
  task automatic exp_pkt(input logic [7:0] st, input logic [7:0] x,
                         input logic [7:0] y);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      get_byte(b);
      if (b === PTR_HEADER) break;
    end
    chk_byte(b, PTR_HEADER);
    exp_byte(st);
    exp_byte(x);
    exp_byte(y);
  endtask
  task automatic sample(input logic [9:0] l, input logic [9:0] r,
                        input logic [9:0] u, input logic [9:0] d);
    @(posedge clk);
    sensor_valid <= 1'b1;
    sensor_in <= '{l, r, u, d};
    @(posedge clk);
    sensor_valid <= 1'b0;
  endtask
  // reading for a pressure; no pressure sits below the baseline
  function automatic logic [9:0] rd(input int p);
    return (p > 0) ? BASE + 10'(p) : BASE - 10'h040;
  endfunction
  function automatic logic [7:0] mag(input int d);
    int a;
    a = ((d < 0) ? -d : d) >> 6;
    return (a > 7) ? 8'h07 : 8'(a);
  endfunction

  initial begin
    logic [7:0] b;
    logic [6:0] c;
    logic [6:0] hk[4];
    logic [7:0] bt[3];
    int i, dx, dy;
    real t0;
    hk = '{K_UP, K_DOWN, K_LEFT, K_RIGHT};
    bt = '{8'h01, 8'h04, 8'h02};
    tick(5);
    srst <= 1'b0;
    @(posedge clk);
    chk_byte({1'b0, brightness}, 8'h31);
    chk_byte({1'b0, contrast}, 8'h31);
    chk_bit(sys_rst_n, 1'b1);
    for (i = 0; i < 8; i++) begin
      c = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'h20 + 7'($random(seed) & 15);
      send_key(1'b0, c);
      send_key(1'b1, c);
      exp_byte({1'b0, c});
      exp_byte({1'b1, c});
    end
    @(posedge clk);
    host_req <= 1'b1;
    tick(2);
    host_req <= 1'b0;
    exp_byte(HOST_ACK);
    tick(20);
    chk_bit(rxq.size() == 0, 1'b1);
    send_key(1'b0, 7'h2a);
    exp_byte(8'h2a);
    exp_byte(8'h2a);
    t0 = $realtime;
    exp_byte(8'h2a);
    chk_bit($realtime - t0 > 74.0 && $realtime - t0 < 86.0, 1'b1);
    send_key(1'b1, 7'h2a);
    for (i = 0; i < 4 && b !== 8'haa; i++) get_byte(b);
    chk_byte(b, 8'haa);
    for (i = 0; i < 4; i++) begin
      c = (i < 2) ? brightness : contrast;
      send_key(1'b0, K_ALT);
      send_key(1'b0, hk[i]);
      tick(6);
      b = {1'b0, c} + ((i % 2) ? 8'h01 : 8'hff);
      chk_byte({1'b0, (i < 2) ? brightness : contrast}, b);
      send_key(1'b1, hk[i]);
      send_key(1'b1, K_ALT);
      exp_byte({1'b0, K_ALT});
      exp_byte({1'b1, K_ALT});
    end
    send_key(1'b0, K_ALT);
    send_key(1'b0, K_UP);
    tick(1300);
    chk_byte({1'b0, brightness}, {1'b0, SETTING_MIN});
    send_key(1'b1, K_UP);
    send_key(1'b0, K_DOWN);
    tick(2000);
    chk_byte({1'b0, brightness}, {1'b0, SETTING_MAX});
    send_key(1'b1, K_DOWN);
    send_key(1'b1, K_ALT);
    exp_byte({1'b0, K_ALT});
    exp_byte({1'b1, K_ALT});
    send_key(1'b0, K_ALT);
    send_key(1'b0, K_ESC);
    send_key(1'b0, K_R);
    for (i = 0; i < 50 && sys_rst_n !== 1'b0; i++) @(posedge clk);
    chk_bit(sys_rst_n, 1'b0);
    chk_bit(user_reset, 1'b1);
    send_key(1'b1, K_R);
    send_key(1'b1, K_ESC);
    send_key(1'b1, K_ALT);
    exp_byte({1'b0, K_ALT});
    exp_byte({1'b1, K_ALT});
    for (i = 0; i < 200 && sys_rst_n !== 1'b1; i++) @(posedge clk);
    chk_bit(sys_rst_n, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    tick(2);
    chk_bit(key_ready, 1'b0);
    ce <= 1'b1;
    srst <= 1'b1;
    tick(5);
    srst <= 1'b0;
    @(posedge clk);
    rxq.delete();
    chk_bit(user_reset, 1'b0);
    sample(BASE, BASE, BASE, BASE);
    tick(60);
    chk_bit(rxq.size() == 0, 1'b1);
    for (i = 0; i < 3; i++) begin
      send_key(1'b0, K_BTN_L + 7'(i));
      exp_pkt(8'h08 | bt[i], 8'h00, 8'h00);
      send_key(1'b1, K_BTN_L + 7'(i));
      exp_pkt(8'h08, 8'h00, 8'h00);
    end
    tick(60);
    chk_bit(rxq.size() == 0, 1'b1);
    stall_en <= 1'b1;
    for (i = 0; i < 8; i++) begin
      dx = (i == 0) ? 575 : (i == 1) ? 64 : 64 + ($random(seed) & 32'h1ff);
      dy = ($random(seed) & 1) ? 0 : 64 + ($random(seed) & 32'h1ff);
      if ($random(seed) & 1) dx = -dx;
      if (i[1]) dy = -dy;
      sample(rd(-dx), rd(dx), rd(dy), rd(-dy));
      tick(40);
      rxq.delete();
      exp_pkt({2'b00, dy < 0, dx < 0, 4'h8}, mag(dx), mag(dy));
    end
    stall_en <= 1'b0;
    sample(BASE, BASE, BASE, BASE);
    tick(60);
    rxq.delete();
    tick(60);
    chk_bit(rxq.size() == 0, 1'b1);
    give_verdict();
  end
endmodule
